// *** design/dsp_pkg.sv ***
// constants, register map and timing for the dual serial port register block
package dsp_pkg;

   // ***********************************************************
   // register indices and byte addresses
   // ***********************************************************
   localparam int          IDX_SERIAL0_DATA_BUFFER     = 'h99;
   localparam int          IDX_INTERRUPT_ENABLE_SECOND = 'h9a;
   localparam int          IDX_SERIAL1_CONTROL         = 'h9b;
   localparam int          IDX_SERIAL1_DATA            = 'h9c;
   localparam int          IDX_INT_STATUS              = 'ha0;
   localparam int          IDX_INT_MASK                = 'ha1;
   localparam int          ADDR_W                      = 12;
   localparam logic [11:0] ADDR_S0DATA   = 12'(IDX_SERIAL0_DATA_BUFFER * 4);
   localparam logic [11:0] ADDR_IRQEN    = 12'(IDX_INTERRUPT_ENABLE_SECOND * 4);
   localparam logic [11:0] ADDR_S1CTRL   = 12'(IDX_SERIAL1_CONTROL * 4);
   localparam logic [11:0] ADDR_S1DATA   = 12'(IDX_SERIAL1_DATA * 4);
   localparam logic [11:0] ADDR_ISTAT    = 12'(IDX_INT_STATUS * 4);
   localparam logic [11:0] ADDR_IMASK    = 12'(IDX_INT_MASK * 4);

   // ***********************************************************
   // field positions and reset values
   // ***********************************************************
   localparam int          BIT_PORT1_IRQ_ENABLE      = 0;
   localparam int          BIT_PORT1_MODE_SELECT     = 7;
   localparam int          BIT_PORT1_MULTIPROC       = 5;
   localparam int          BIT_PORT1_RECEIVE_ENABLE  = 4;
   localparam int          BIT_PORT1_TX_NINTH        = 3;
   localparam int          BIT_PORT1_RX_NINTH        = 2;
   localparam int          BIT_PORT1_TX_DONE         = 1;
   localparam int          BIT_PORT1_RX_DONE         = 0;
   localparam int          EV_W                      = 4;
   localparam logic [7:0]  RST_BYTE                  = 8'h00;
   localparam logic [3:0]  RST_EVENTS                = 4'h0;
   localparam logic [1:0]  RESP_OKAY                 = 2'h0;
   localparam logic [1:0]  RESP_SLVERR               = 2'h2;

   // ***********************************************************
   // bit timing
   // ***********************************************************
   localparam int          CLK_HZ      = 10_000_000;
   localparam int          BAUD_HZ     = 115_200;
   localparam int          BIT_CYCLES  = CLK_HZ / BAUD_HZ;
   localparam int          HALF_CYCLES = BIT_CYCLES / 2;
   localparam int          CNT_W       = 8;
   localparam logic [7:0]  BIT_LAST    = 8'(BIT_CYCLES - 1);
   localparam logic [7:0]  HALF_LAST   = 8'(HALF_CYCLES - 1);
   localparam logic [3:0]  FRAME_BITS9 = 4'hb;
   localparam logic [3:0]  FRAME_BITS8 = 4'ha;

endpackage

// *** design/dsp_regs.sv ***
// serial lane engine and the register block for two serial ports
//
// How it works
// - writing port-0 buffer while the transmitter is idle loads the transmit holding byte and starts sending it.
// - reading port-0 buffer returns the receive buffer, never the transmit byte.
// - port 0 sends and receives at the same time, independently.
// - port-0 receiver keeps exactly one received byte beyond the shift path.
// - only enable bit 0 exists; when clear the port-1 interrupt is blocked.
// - port-1 control bit 7 picks mode; in mode A bit 3 is sent as ninth bit.
// - hardware sets port-1 transmit-done flag; only software clears it.
// - hardware sets port-1 receive-done flag; only software clears it.
`timescale 1ns/1ps

module dsp_lane
   import dsp_pkg::*;
(
   input  wire logic       aclk,     // system clock
   input  wire logic       aresetn,  // synchronous reset, active low
   input  wire logic       nine,     // frame carries nine data bits
   input  wire logic       tx_go,    // start sending tx_word
   input  wire logic [8:0] tx_word,  // word to send, bit 8 used when nine
   output logic            tx_busy,  // frame on the line
   output logic            tx_done,  // pulse at the end of the stop bit
   output logic            txd,      // serial out, idle high
   input  wire logic       rxd,      // synchronised serial in
   input  wire logic       rx_en,    // receiver enabled
   output logic            rx_done,  // pulse when a frame has been shifted in
   output logic [8:0]      rx_word,  // received word, bit 8 used when nine
   output logic            rx_stop   // received stop bit
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} dsp_rx_e;

   logic [10:0]      tx_sh_r;
   logic [CNT_W-1:0] tx_cnt_r;
   logic [3:0]       tx_bits_r;
   dsp_rx_e          rx_st_r;
   logic [CNT_W-1:0] rx_cnt_r;
   logic [3:0]       rx_bits_r;
   logic [9:0]       rx_sh_r;

   assign txd     = tx_sh_r[0];
   assign rx_word = nine ? rx_sh_r[8:0] : {1'b0, rx_sh_r[8:1]};
   assign rx_stop = rx_sh_r[9];

   // ***********************************************************
   // transmitter
   // ***********************************************************
   always_ff @(posedge aclk) begin
      tx_done <= 1'b0;
      if (!aresetn) begin
         tx_sh_r   <= '1;
         tx_cnt_r  <= '0;
         tx_bits_r <= '0;
         tx_busy   <= 1'b0;
      end else if (!tx_busy) begin
         if (tx_go) begin
            tx_sh_r   <= nine ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
            tx_bits_r <= nine ? FRAME_BITS9 : FRAME_BITS8;
            tx_cnt_r  <= '0;
            tx_busy   <= 1'b1;
         end
      end else if (tx_cnt_r == BIT_LAST) begin
         tx_cnt_r  <= '0;
         tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
         tx_bits_r <= tx_bits_r - 4'h1;
         if (tx_bits_r == 4'h1) begin
            tx_busy <= 1'b0;
            tx_done <= 1'b1;
         end
      end else begin
         tx_cnt_r <= tx_cnt_r + 8'h01;
      end
   end

   // ***********************************************************
   // receiver, runs on its own beside the transmitter
   // ***********************************************************
   always_ff @(posedge aclk) begin
      rx_done <= 1'b0;
      if (!aresetn) begin
         rx_st_r   <= RX_IDLE;
         rx_cnt_r  <= '0;
         rx_bits_r <= '0;
         rx_sh_r   <= '0;
      end else if (!rx_en) begin
         rx_st_r <= RX_IDLE;
      end else begin
         case (rx_st_r)
            RX_IDLE: begin
               rx_cnt_r <= '0;
               if (!rxd) begin
                  rx_st_r <= RX_START;
               end
            end
            RX_START: begin
               if (rx_cnt_r == HALF_LAST) begin
                  rx_cnt_r  <= '0;
                  rx_bits_r <= nine ? FRAME_BITS9 - 4'h1 : FRAME_BITS8 - 4'h1;
                  rx_st_r   <= rxd ? RX_IDLE : RX_DATA;
               end else begin
                  rx_cnt_r <= rx_cnt_r + 8'h01;
               end
            end
            RX_DATA: begin
               if (rx_cnt_r == BIT_LAST) begin
                  rx_cnt_r  <= '0;
                  rx_sh_r   <= {rxd, rx_sh_r[9:1]};
                  rx_bits_r <= rx_bits_r - 4'h1;
                  if (rx_bits_r == 4'h1) begin
                     rx_done <= 1'b1;
                     rx_st_r <= RX_IDLE;
                  end
               end else begin
                  rx_cnt_r <= rx_cnt_r + 8'h01;
               end
            end
            default: begin
               rx_st_r <= RX_IDLE;
            end
         endcase
      end
   end
endmodule

module dsp_regs
   import dsp_pkg::*;
(
   input  wire logic              aclk,          // system clock, 10 MHz
   input  wire logic              aresetn,       // synchronous reset, active low
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
   input  wire logic              s_axi_awvalid, // write address valid
   output logic                   s_axi_awready, // write address ready
   input  wire logic [31:0]       s_axi_wdata,   // write data
   input  wire logic [3:0]        s_axi_wstrb,   // byte enables
   input  wire logic              s_axi_wvalid,  // write data valid
   output logic                   s_axi_wready,  // write data ready
   output logic [1:0]             s_axi_bresp,   // write response
   output logic                   s_axi_bvalid,  // write response valid
   input  wire logic              s_axi_bready,  // write response ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
   input  wire logic              s_axi_arvalid, // read address valid
   output logic                   s_axi_arready, // read address ready
   output logic [31:0]            s_axi_rdata,   // read data
   output logic [1:0]             s_axi_rresp,   // read response
   output logic                   s_axi_rvalid,  // read data valid
   input  wire logic              s_axi_rready,  // read data ready
   output logic                   serial0_txd,   // port 0 serial out
   input  wire logic              serial0_rxd,   // port 0 serial in, asynchronous
   output logic                   serial1_txd,   // port 1 serial out
   input  wire logic              serial1_rxd,   // port 1 serial in, asynchronous
   output logic                   port1_irq,     // port 1 interrupt request
   output logic                   irq            // masked event interrupt, level
);
   logic            wr_go, rd_go, wr_hit, rd_hit;
   logic            wr_s0data, wr_irqen, wr_s1ctrl, wr_s1data, wr_istat, wr_imask;
   logic [1:0]      rx0_sync_r, rx1_sync_r;
   logic [7:0]      s0_tx_hold_r, s0_rx_buf_r, s1_rx_buf_r;
   logic            port1_irq_enable_r;
   logic            port1_mode_select_r, port1_multiproc_enable_r;
   logic            port1_receive_enable_r, port1_tx_ninth_bit_r, port1_rx_ninth_bit_r;
   logic            port1_tx_done_flag_r, port1_rx_done_flag_r;
   logic [EV_W-1:0] int_status_r, int_mask_r, events;
   logic            tx0_busy, tx0_done, rx0_done;
   logic            tx1_busy, tx1_done, rx1_done, rx1_stop, rx1_accept, nine1;
   logic [8:0]      rx0_word, rx1_word, tx1_word;
   logic [7:0]      serial1_control;

   // ***********************************************************
   // axi4-lite slave
   // ***********************************************************
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
   assign wr_hit = s_axi_awaddr inside {ADDR_S0DATA, ADDR_IRQEN, ADDR_S1CTRL,
                                        ADDR_S1DATA, ADDR_ISTAT, ADDR_IMASK};
   assign rd_hit = s_axi_araddr inside {ADDR_S0DATA, ADDR_IRQEN, ADDR_S1CTRL,
                                        ADDR_S1DATA, ADDR_ISTAT, ADDR_IMASK};
   assign wr_s0data = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_S0DATA);
   assign wr_irqen  = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_IRQEN);
   assign wr_s1ctrl = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_S1CTRL);
   assign wr_s1data = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_S1DATA);
   assign wr_istat  = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_ISTAT);
   assign wr_imask  = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_IMASK);
   assign serial1_control = {port1_mode_select_r, 1'b0, port1_multiproc_enable_r,
                             port1_receive_enable_r, port1_tx_ninth_bit_r,
                             port1_rx_ninth_bit_r, port1_tx_done_flag_r,
                             port1_rx_done_flag_r};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= '0;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            ADDR_S0DATA: s_axi_rdata <= {24'h0, s0_rx_buf_r};
            ADDR_IRQEN:  s_axi_rdata <= {31'h0, port1_irq_enable_r};
            ADDR_S1CTRL: s_axi_rdata <= {24'h0, serial1_control};
            ADDR_S1DATA: s_axi_rdata <= {24'h0, s1_rx_buf_r};
            ADDR_ISTAT:  s_axi_rdata <= {28'h0, int_status_r};
            ADDR_IMASK:  s_axi_rdata <= {28'h0, int_mask_r};
            default:     s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ***********************************************************
   // line input synchronisers
   // ***********************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx0_sync_r <= 2'h3;
         rx1_sync_r <= 2'h3;
      end else begin
         rx0_sync_r <= {rx0_sync_r[0], serial0_rxd};
         rx1_sync_r <= {rx1_sync_r[0], serial1_rxd};
      end
   end

   // ***********************************************************
   // serial port 0
   // ***********************************************************
   dsp_lane u_lane0 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .nine    (1'b0),
      .tx_go   (wr_s0data),
      .tx_word ({1'b0, s_axi_wdata[7:0]}),
      .tx_busy (tx0_busy),
      .tx_done (tx0_done),
      .txd     (serial0_txd),
      .rxd     (rx0_sync_r[1]),
      .rx_en   (1'b1),
      .rx_done (rx0_done),
      .rx_word (rx0_word),
      .rx_stop ()
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s0_tx_hold_r <= RST_BYTE;
         s0_rx_buf_r  <= RST_BYTE;
      end else begin
         if (wr_s0data && !tx0_busy) begin
            s0_tx_hold_r <= s_axi_wdata[7:0];
         end
         if (rx0_done) begin
            s0_rx_buf_r <= rx0_word[7:0];
         end
      end
   end

   // ***********************************************************
   // serial port 1
   // ***********************************************************
   assign nine1    = !port1_mode_select_r;
   assign tx1_word = {port1_tx_ninth_bit_r, s_axi_wdata[7:0]};
   assign rx1_accept = rx1_done && port1_receive_enable_r &&
                       (!port1_multiproc_enable_r || (nine1 ? rx1_word[8] : rx1_stop));

   dsp_lane u_lane1 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .nine    (nine1),
      .tx_go   (wr_s1data),
      .tx_word (tx1_word),
      .tx_busy (tx1_busy),
      .tx_done (tx1_done),
      .txd     (serial1_txd),
      .rxd     (rx1_sync_r[1]),
      .rx_en   (port1_receive_enable_r),
      .rx_done (rx1_done),
      .rx_word (rx1_word),
      .rx_stop (rx1_stop)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_rx_buf_r <= RST_BYTE;
      end else begin
         if (rx1_accept) begin
            s1_rx_buf_r <= rx1_word[7:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port1_mode_select_r      <= 1'b0;
         port1_multiproc_enable_r <= 1'b0;
         port1_receive_enable_r   <= 1'b0;
         port1_tx_ninth_bit_r     <= 1'b0;
         port1_rx_ninth_bit_r     <= 1'b0;
         port1_tx_done_flag_r     <= 1'b0;
         port1_rx_done_flag_r     <= 1'b0;
         port1_irq_enable_r       <= 1'b0;
      end else begin
         if (wr_irqen) begin
            port1_irq_enable_r <= s_axi_wdata[BIT_PORT1_IRQ_ENABLE];
         end
         if (wr_s1ctrl) begin
            port1_mode_select_r      <= s_axi_wdata[BIT_PORT1_MODE_SELECT];
            port1_multiproc_enable_r <= s_axi_wdata[BIT_PORT1_MULTIPROC];
            port1_receive_enable_r   <= s_axi_wdata[BIT_PORT1_RECEIVE_ENABLE];
            port1_tx_ninth_bit_r     <= s_axi_wdata[BIT_PORT1_TX_NINTH];
            port1_rx_ninth_bit_r     <= s_axi_wdata[BIT_PORT1_RX_NINTH];
         end
         if (rx1_accept) begin
            port1_rx_ninth_bit_r <= nine1 ? rx1_word[8] : rx1_stop;
         end
         // hardware set wins over a software clear in the same cycle
         port1_tx_done_flag_r <= tx1_done ||
            (wr_s1ctrl ? s_axi_wdata[BIT_PORT1_TX_DONE] : port1_tx_done_flag_r);
         port1_rx_done_flag_r <= rx1_accept ||
            (wr_s1ctrl ? s_axi_wdata[BIT_PORT1_RX_DONE] : port1_rx_done_flag_r);
      end
   end

   assign port1_irq = port1_irq_enable_r &&
                      (port1_tx_done_flag_r || port1_rx_done_flag_r);

   // ***********************************************************
   // event status and mask
   // ***********************************************************
   assign events = {rx1_accept, tx1_done, rx0_done, tx0_done};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_status_r <= RST_EVENTS;
         int_mask_r   <= RST_EVENTS;
      end else begin
         int_status_r <= events | (int_status_r &
                         ~(wr_istat ? s_axi_wdata[EV_W-1:0] : RST_EVENTS));
         if (wr_imask) begin
            int_mask_r <= s_axi_wdata[EV_W-1:0];
         end
      end
   end

   assign irq = |(int_status_r & int_mask_r);

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_s0data_wr_idle;
      wr_s0data && !tx0_busy;
   endsequence
   sequence seq_s1ctrl_quiet;
      !wr_s1ctrl;
   endsequence

   chk_tx0_start_now: assert property (seq_s0data_wr_idle |=> tx0_busy && !serial0_txd)
      else $error("port 0 write did not start a frame");

   chk_tx0_hold_load: assert property (seq_s0data_wr_idle
      |=> s0_tx_hold_r == $past(s_axi_wdata[7:0]))
      else $error("port 0 holding byte not loaded");

   chk_rx0_read_buf: assert property (rd_go && s_axi_araddr == ADDR_S0DATA
      |=> s_axi_rdata[7:0] == $past(s0_rx_buf_r))
      else $error("port 0 read did not return the receive buffer");

   chk_rx0_duplex: assert property (rx0_done && tx0_busy
      |=> int_status_r[1] && s0_rx_buf_r == $past(rx0_word[7:0]))
      else $error("port 0 reception lost while sending");

   chk_rx0_one_byte: assert property (!rx0_done |=> $stable(s0_rx_buf_r))
      else $error("port 0 receive buffer changed without a frame");

   chk_irq_blocked: assert property (!port1_irq_enable_r |-> !port1_irq)
      else $error("port 1 interrupt passed while disabled");

   chk_ninth_bit_sent: assert property (wr_s1data && !tx1_busy && nine1
      ##1 (tx1_busy && !serial1_txd) |-> u_lane1.tx_sh_r[9] == $past(port1_tx_ninth_bit_r))
      else $error("mode A ninth bit not taken from control bit 3");

   chk_tx_flag_sticky: assert property (port1_tx_done_flag_r ##0 seq_s1ctrl_quiet
      |=> port1_tx_done_flag_r)
      else $error("port 1 transmit flag cleared by hardware");

   chk_tx_flag_set: assert property (tx1_done |=> port1_tx_done_flag_r)
      else $error("port 1 transmit flag not set");

   chk_rx_flag_kept: assert property (rx1_accept |=> port1_rx_done_flag_r ##1
      (port1_rx_done_flag_r || $past(wr_s1ctrl)))
      else $error("port 1 receive flag not set or dropped");

   chk_irq_or_flags: assert property ((port1_tx_done_flag_r || port1_rx_done_flag_r)
      && port1_irq_enable_r |-> port1_irq)
      else $error("port 1 interrupt missing for a set flag");

   chk_rx_disabled: assert property (!port1_receive_enable_r && !port1_rx_done_flag_r
      ##0 seq_s1ctrl_quiet |=> !port1_rx_done_flag_r)
      else $error("port 1 receive flag set while receiver disabled");

endmodule

// *** sim/dsp_far_end.sv ***
// far-end serial transceiver model for the register block bench
`timescale 1ns/1ps
module dsp_far_end
   import dsp_pkg::*;
#(
   parameter int NBITS = 10  // start, data, optional ninth, stop
)(
   input  wire logic aclk,     // system clock
   input  wire logic line_in,  // frames sent by the block
   output logic      line_out  // frames sent to the block, idle high
);
   // ***********************************************************
   // capture and send
   // ***********************************************************
   logic [10:0] got;
   int          frames = 0;
   initial line_out = 1'b1;
   // sample every bit in its middle, start bit lands in bit 0
   always begin
      @(negedge line_in);
      repeat (HALF_CYCLES) @(posedge aclk);
      for (int i = 0; i < NBITS - 1; i++) begin
         got[i] = line_in;
         repeat (BIT_CYCLES) @(posedge aclk);
      end
      got[NBITS-1] = line_in;
      frames++;
   end
   task automatic send(input logic [10:0] w);
      for (int i = 0; i < NBITS; i++) begin
         line_out <= w[i];
         repeat (BIT_CYCLES) @(posedge aclk);
      end
   endtask
endmodule

// *** sim/dual_serial_port_regs_bench.sv ***
// self-checking bench for the serial port register block
`timescale 1ns/1ps
module dual_serial_port_regs_bench
   import dsp_pkg::*;
;
   // ***********************************************************
   // signals, design and far ends
   // ***********************************************************
   logic              aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0]       wdata = '0, rdata;
   logic [1:0]        bresp, rresp;
   logic              awready, wready, bvalid, arready, rvalid, txd0, txd1, rxd0, rxd1, p1irq, irq;
   int                fails = 0, cmp_count = 0;
   dsp_regs i_dsp_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .serial0_txd(txd0),
      .serial0_rxd(rxd0), .serial1_txd(txd1), .serial1_rxd(rxd1), .port1_irq(p1irq), .irq(irq));
   dsp_far_end #(.NBITS(10)) i_dsp_far_end0 (.aclk(aclk), .line_in(txd0), .line_out(rxd0));
   dsp_far_end #(.NBITS(11)) i_dsp_far_end1 (.aclk(aclk), .line_in(txd1), .line_out(rxd1));
   initial forever #50 aclk = ~aclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk(32'(bresp), 32'(RESP_OKAY), "write response");
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string what,
                     input logic [1:0] er = RESP_OKAY);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata, exp, what);
      chk(32'(rresp), 32'(er), "read response");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_reset();
      rc(ADDR_S0DATA, 32'h0, "buffer reset");
      rc(ADDR_IRQEN, 32'h0, "enable reset");
      rc(ADDR_S1CTRL, 32'h0, "control reset");
      rc(12'h000, 32'h0, "unmapped", RESP_SLVERR);
   endtask
   task automatic t_port0();
      fork
         wr(ADDR_S0DATA, 8'ha5);
         i_dsp_far_end0.send({2'b11, 8'h3c, 1'b0});
      join
      repeat (10 * BIT_CYCLES + 20) @(posedge aclk);
      chk(32'(i_dsp_far_end0.got[8:1]), 32'ha5, "port0 sent byte");
      chk(32'(i_dsp_far_end0.frames), 32'h1, "port0 frame count");
      rc(ADDR_S0DATA, 32'h3c, "port0 received byte");
      i_dsp_far_end0.send({2'b11, 8'h81, 1'b0});
      repeat (20) @(posedge aclk);
      rc(ADDR_S0DATA, 32'h81, "port0 buffer replaced");
      chk(32'(irq), 32'h0, "irq masked");
      wr(ADDR_IMASK, 8'h03);
      chk(32'(irq), 32'h1, "irq raised");
      wr(ADDR_ISTAT, 8'h03);
      chk(32'(irq), 32'h0, "irq cleared");
   endtask
   task automatic t_p1_tx();
      for (int tb = 1; tb >= 0; tb--) begin
         wr(ADDR_S1CTRL, 8'(tb << 3));
         wr(ADDR_S1DATA, 8'h5a);
         repeat (11 * BIT_CYCLES + 20) @(posedge aclk);
         chk(32'(i_dsp_far_end1.got[9:1]), {23'h0, tb[0], 8'h5a}, "port1 frame");
         rc(ADDR_S1CTRL, 32'h2 | 32'(tb << 3), "tx done kept");
         chk(32'(p1irq), 32'h0, "port1 irq blocked");
         wr(ADDR_IRQEN, 8'h01);
         chk(32'(p1irq), 32'h1, "port1 irq raised");
         wr(ADDR_S1CTRL, 8'(tb << 3));
         chk(32'(p1irq), 32'h0, "tx done cleared");
         wr(ADDR_IRQEN, 8'h00);
      end
   endtask
   task automatic t_p1_rx();
      wr(ADDR_S1CTRL, 8'h00);
      i_dsp_far_end1.send({2'b11, 8'h66, 1'b0});
      repeat (20) @(posedge aclk);
      rc(ADDR_S1CTRL, 32'h0, "receiver off");
      wr(ADDR_S1CTRL, 8'h10);
      i_dsp_far_end1.send({2'b11, 8'h66, 1'b0});
      repeat (20) @(posedge aclk);
      rc(ADDR_S1CTRL, 32'h15, "rx done set");
      rc(ADDR_S1DATA, 32'h66, "port1 received byte");
   endtask
   task automatic t_p1_modes();
      wr(ADDR_S1CTRL, 8'h80);
      wr(ADDR_S1DATA, 8'hc3);
      repeat (11 * BIT_CYCLES + 20) @(posedge aclk);
      chk(32'(i_dsp_far_end1.got[9:1]), 32'h1c3, "mode B frame");
      chk(32'(i_dsp_far_end1.frames), 32'h3, "port1 frame count");
      rc(ADDR_S1CTRL, 32'h82, "mode B tx done");
      wr(ADDR_S1CTRL, 8'h30);
      i_dsp_far_end1.send({2'b10, 8'h99, 1'b0});
      repeat (20) @(posedge aclk);
      rc(ADDR_S1CTRL, 32'h30, "ninth bit clear refused");
      rc(ADDR_S1DATA, 32'h66, "port1 buffer kept");
      wr(ADDR_S1CTRL, 8'hb0);
      i_dsp_far_end1.send({2'b11, 8'h42, 1'b0});
      repeat (20) @(posedge aclk);
      rc(ADDR_S1CTRL, 32'hb5, "mode B rx done");
      rc(ADDR_S1DATA, 32'h42, "mode B received byte");
      rc(ADDR_ISTAT, 32'hc, "port1 events");
      chk(32'(irq), 32'h0, "port1 events masked");
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_port0();
      t_p1_tx();
      t_p1_rx();
      t_p1_modes();
      give_verdict();
   end
   initial begin
      repeat (30000) @(posedge aclk);
      fails++;
      give_verdict();
   end
endmodule
